// *** core/psu_upload.sv ***
// How it works
// - registering an upload with -1 on parameter 80 works only at standstill.
// - a registered upload holds the drive off until the sequence ends.
// - values written during upload go to a shadow set, unchecked.
// - only parameters with the card-loadable attribute are changed.
// - writes to other parameters are acknowledged but not stored; a write to parameter 150 is refused.
// - writing -2 to parameter 80 ends the transfer and starts a full check.
// - a failed check drops the shadow set and keeps the old active set.
// - a passed check commits card-loadable values, re-enables, reports 0.
// - while checking and saving, parameter 80 reads -1.
// - on rejection parameter 80 reads the number of the first bad one.
module psu_upload
  import psu_pkg::*;
(
  input  wire logic             i_clk,
  input  wire logic             i_resetn,
  input  wire logic             i_req_valid,
  input  wire psu_req_t         i_req,
  input  wire logic             i_standstill,
  input  wire logic [NPARAM-1:0] i_card_loadable,
  output psu_rsp_t              o_rsp,
  output logic                  o_rsp_valid,
  output logic                  o_drive_inhibit,
  output logic                  o_nvm_we,
  output logic [IDX_W-1:0]      o_nvm_addr,
  output logic [VAL_W-1:0]      o_nvm_data,
  output logic                  o_persist_req
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef enum logic [4:0] {
    ST_IDLE   = 5'b00001,
    ST_LOAD   = 5'b00010,
    ST_CHECK  = 5'b00100,
    ST_COMMIT = 5'b01000,
    ST_WAIT   = 5'b10000
  } psu_state_t;

  psu_state_t        state_q, state_d;
  logic [VAL_W-1:0]  active_q [NPARAM];
  logic [VAL_W-1:0]  shadow_q [NPARAM];
  logic [VAL_W-1:0]  lo_q     [NPARAM];
  logic [VAL_W-1:0]  hi_q     [NPARAM];
  logic [VAL_W-1:0]  upc_q, upc_d;
  logic [IDX_W-1:0]  idx_q, idx_d;
  logic [15:0]       wcnt_q, wcnt_d;
  psu_rsp_t          rsp_q, rsp_d;
  logic              rsp_v_q;
  logic              nvm_we_q;
  logic [IDX_W-1:0]  nvm_addr_q;
  logic [VAL_W-1:0]  nvm_data_q;
  logic              persist_q;

  // ---------------------------------------------------------------
  // request decode
  // ---------------------------------------------------------------
  wire               is_upc    = (i_req.pnum == PNUM_UPLOAD_CTRL);
  wire               is_pers   = (i_req.pnum == PNUM_PERSIST);
  wire               in_range  = (i_req.pnum < PNUM_W'(NPARAM));
  wire [IDX_W-1:0]   ridx      = i_req.pnum[IDX_W-1:0];
  wire               wr        = i_req_valid && i_req.write;
  wire               rd        = i_req_valid && !i_req.write;
  wire               upc_wr    = wr && is_upc;
  wire               upc_ok    = upc_wr && i_standstill;
  wire               reg_up    = upc_ok && (i_req.value == UPC_REGISTER)
                                 && ((state_q == ST_IDLE) ||
                                     (state_q == ST_WAIT));
  wire               end_up    = upc_ok && (i_req.value == UPC_END)
                                 && (state_q == ST_LOAD);
  wire               loading   = (state_q == ST_LOAD);
  wire               busy      = (state_q == ST_CHECK) ||
                                 (state_q == ST_COMMIT);
  wire               card_ok   = in_range && i_card_loadable[ridx];
  wire               shadow_we = wr && loading && !is_upc && card_ok;
  wire               direct_we = wr && (state_q == ST_IDLE ||
                                 state_q == ST_WAIT) && !is_upc
                                 && !is_pers && in_range;
  wire               chk_ok;
  wire               last_idx  = (idx_q == IDX_W'(NPARAM - 1));
  wire               nvm_done  = (wcnt_q == 16'(NVM_WRITE_CYC - 1));

  // ---------------------------------------------------------------
  // whole-set check, one parameter per cycle
  // ---------------------------------------------------------------
  psu_range_chk u_chk (
    .i_value (shadow_q[idx_q]),
    .i_lo    (lo_q[idx_q]),
    .i_hi    (hi_q[idx_q]),
    .o_ok    (chk_ok)
  );

  // ---------------------------------------------------------------
  // direct writes checked per parameter outside an upload
  // ---------------------------------------------------------------
  wire direct_ok = (i_req.value >= lo_q[ridx]) &&
                   (i_req.value <= hi_q[ridx]);

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    upc_d   = upc_q;
    idx_d   = idx_q;
    wcnt_d  = wcnt_q;
    case (state_q)
      ST_IDLE, ST_WAIT: begin
        if (reg_up) begin
          state_d = ST_LOAD;
          upc_d   = UPC_REGISTER;
        end
      end
      ST_LOAD: begin
        if (end_up) begin
          state_d = ST_CHECK;
          upc_d   = UPC_BUSY;
          idx_d   = '0;
        end
      end
      ST_CHECK: begin
        if (!chk_ok && i_card_loadable[idx_q]) begin
          state_d = ST_WAIT;
          upc_d   = VAL_W'(idx_q);
        end else if (last_idx) begin
          state_d = ST_COMMIT;
          idx_d   = '0;
          wcnt_d  = '0;
        end else begin
          idx_d = idx_q + IDX_W'(1);
        end
      end
      ST_COMMIT: begin
        if (!i_card_loadable[idx_q] || nvm_done) begin
          wcnt_d = '0;
          if (last_idx) begin
            state_d = ST_WAIT;
            upc_d   = UPC_DONE;
          end else begin
            idx_d = idx_q + IDX_W'(1);
          end
        end else begin
          wcnt_d = wcnt_q + 16'h0001;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      state_q <= ST_IDLE;
      upc_q   <= UPC_DONE;
      idx_q   <= '0;
      wcnt_q  <= '0;
    end else begin
      state_q <= state_d;
      upc_q   <= upc_d;
      idx_q   <= idx_d;
      wcnt_q  <= wcnt_d;
    end
  end

  // ---------------------------------------------------------------
  // reply composition
  // ---------------------------------------------------------------
  always_comb begin
    rsp_d = '{status: ST_OK, value: '0};
    if (is_upc) begin
      if (upc_wr && !i_standstill) begin
        rsp_d.status = ST_NOTSTILL;
      end else if (upc_wr && !(reg_up || end_up)) begin
        rsp_d.status = ST_BADVAL;
      end
      rsp_d.value = upc_q;
    end else if (is_pers) begin
      rsp_d.status = busy || loading ? ST_BADVAL : ST_OK;
    end else if (!in_range) begin
      rsp_d.status = ST_BADNUM;
    end else if (rd) begin
      rsp_d.value = active_q[ridx];
    end else if (busy) begin
      rsp_d.status = ST_BADVAL;
    end else if (loading) begin
      rsp_d.status = ST_OK;
    end else if (!direct_ok) begin
      rsp_d.status = ST_BADVAL;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      rsp_q     <= '0;
      rsp_v_q   <= 1'b0;
      persist_q <= 1'b0;
    end else begin
      rsp_q     <= rsp_d;
      rsp_v_q   <= i_req_valid;
      persist_q <= wr && is_pers && !busy && !loading;
    end
  end

  // ---------------------------------------------------------------
  // parameter stores: shadow collects, active commits
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (reg_up) begin
      shadow_q <= active_q;
    end else if (shadow_we) begin
      shadow_q[ridx] <= i_req.value;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      for (int i = 0; i < NPARAM; i++) begin
        active_q[i] <= '0;
        lo_q[i]     <= '0;
        hi_q[i]     <= 32'h7fffffff;
      end
    end else if (state_q == ST_COMMIT && i_card_loadable[idx_q]) begin
      active_q[idx_q] <= shadow_q[idx_q];
    end else if (direct_we && direct_ok) begin
      active_q[ridx] <= i_req.value;
    end
  end

  // ---------------------------------------------------------------
  // non-volatile write port
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      nvm_we_q   <= 1'b0;
      nvm_addr_q <= '0;
      nvm_data_q <= '0;
    end else begin
      nvm_we_q   <= (state_q == ST_COMMIT) && i_card_loadable[idx_q]
                    && (wcnt_q == 16'h0000);
      nvm_addr_q <= idx_q;
      nvm_data_q <= shadow_q[idx_q];
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign o_rsp           = rsp_q;
  assign o_rsp_valid     = rsp_v_q;
  assign o_drive_inhibit = loading || busy;
  assign o_nvm_we        = nvm_we_q;
  assign o_nvm_addr      = nvm_addr_q;
  assign o_nvm_data      = nvm_data_q;
  assign o_persist_req   = persist_q;

endmodule

// *** pkg/psu_pkg.sv ***
package psu_pkg;

  // ---------------------------------------------------------------
  // parameter numbering
  // ---------------------------------------------------------------
  localparam int unsigned PNUM_W        = 10;
  localparam int unsigned VAL_W         = 32;
  localparam int unsigned NPARAM        = 256;
  localparam int unsigned IDX_W         = 8;
  localparam logic [PNUM_W-1:0] PNUM_UPLOAD_CTRL = 10'h050; // 80
  localparam logic [PNUM_W-1:0] PNUM_PERSIST     = 10'h096; // 150

  // ---------------------------------------------------------------
  // upload-control values
  // ---------------------------------------------------------------
  localparam logic [VAL_W-1:0] UPC_REGISTER = 32'hffffffff; // -1
  localparam logic [VAL_W-1:0] UPC_END      = 32'hfffffffe; // -2
  localparam logic [VAL_W-1:0] UPC_BUSY     = 32'hffffffff; // -1
  localparam logic [VAL_W-1:0] UPC_DONE     = 32'h00000000;

  // ---------------------------------------------------------------
  // reply status codes
  // ---------------------------------------------------------------
  localparam logic [7:0] ST_OK      = 8'h00;
  localparam logic [7:0] ST_NOTSTILL = 8'h01;
  localparam logic [7:0] ST_BADVAL  = 8'h02;
  localparam logic [7:0] ST_BADNUM  = 8'h03;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_MHZ      = 100;
  localparam int unsigned NVM_WRITE_NS = 100;
  localparam int unsigned NVM_WRITE_CYC =
    (NVM_WRITE_NS * CLK_MHZ + 999) / 1000;

  // ---------------------------------------------------------------
  // telegram carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic              write;
    logic [PNUM_W-1:0] pnum;
    logic [VAL_W-1:0]  value;
  } psu_req_t;

  typedef struct packed {
    logic [7:0]       status;
    logic [VAL_W-1:0] value;
  } psu_rsp_t;

endpackage

// *** core/psu_range_chk.sv ***
module psu_range_chk
  import psu_pkg::*;
(
  input  wire logic [VAL_W-1:0] i_value,
  input  wire logic [VAL_W-1:0] i_lo,
  input  wire logic [VAL_W-1:0] i_hi,
  output logic                  o_ok
);

  // ---------------------------------------------------------------
  // unsigned window compare
  // ---------------------------------------------------------------
  assign o_ok = (i_value >= i_lo) && (i_value <= i_hi);

endmodule

// *** sim/psu_upload_monitor.sv ***
module psu_upload_monitor
  import psu_pkg::*;
(
  input wire logic              i_clk,
  input wire logic              i_resetn,
  input wire logic              i_req_valid,
  input wire psu_req_t          i_req,
  input wire logic              i_standstill,
  input wire logic [NPARAM-1:0] i_card_loadable,
  input wire psu_rsp_t          o_rsp,
  input wire logic              o_rsp_valid,
  input wire logic              o_drive_inhibit,
  input wire logic              o_nvm_we,
  input wire logic [IDX_W-1:0]  o_nvm_addr,
  input wire logic [VAL_W-1:0]  o_nvm_data,
  input wire logic              o_persist_req
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  // telegram decode
  wire logic wr80   = i_req_valid && i_req.write
                      && i_req.pnum == PNUM_UPLOAD_CTRL;
  wire logic reg_ok = wr80 && i_standstill && i_req.value == UPC_REGISTER;
  wire logic per_wr = i_req_valid && i_req.write
                      && i_req.pnum == PNUM_PERSIST;
  // ------------------------------------------------------------
  // port relations
  // ------------------------------------------------------------
  ack_every_a: assert property (i_req_valid |=> o_rsp_valid)
    else $error("reply missing");
  reg_inhibit_a: assert property (reg_ok && !o_drive_inhibit |=>
    o_drive_inhibit && o_rsp.status == ST_OK) else $error("no register");
  inhibit_rise_a: assert property ($rose(o_drive_inhibit) |->
    $past(reg_ok)) else $error("inhibit without register");
  moving_ref_a: assert property (wr80 && !i_standstill
    && !o_drive_inhibit |=> o_rsp.status == ST_NOTSTILL
    && !o_drive_inhibit) else $error("moving write taken");
  end_hold_a: assert property (wr80 && i_req.value == UPC_END
    && o_drive_inhibit |=> (o_rsp.status != ST_OK)
    or (o_drive_inhibit [*8])) else $error("inhibit dropped early");
  nvm_loadable_a: assert property (o_nvm_we |->
    i_card_loadable[o_nvm_addr]) else $error("non loadable stored");
  nvm_upload_a: assert property (o_nvm_we |->
    $past(o_drive_inhibit)) else $error("store outside upload");
  persist_cause_a: assert property (o_persist_req |->
    $past(per_wr)) else $error("persist without write");
endmodule
bind psu_upload psu_upload_monitor psu_upload_monitor_i (
  .i_clk(i_clk), .i_resetn(i_resetn), .i_req_valid(i_req_valid),
  .i_req(i_req), .i_standstill(i_standstill), .o_rsp(o_rsp),
  .i_card_loadable(i_card_loadable), .o_rsp_valid(o_rsp_valid),
  .o_drive_inhibit(o_drive_inhibit), .o_nvm_we(o_nvm_we),
  .o_nvm_addr(o_nvm_addr), .o_nvm_data(o_nvm_data),
  .o_persist_req(o_persist_req));

// *** sim/psu_master.sv ***
module psu_master
  import psu_pkg::*;
(
  input  wire logic     i_clk,
  output psu_req_t      o_req,
  output logic          o_req_valid,
  input  wire psu_rsp_t i_rsp,
  input  wire logic     i_rsp_valid
);
  timeunit 1ns;
  timeprecision 100ps;
  // idle bus from time zero
  initial begin
    o_req_valid = 1'b0;
    o_req = '0;
  end
  // one telegram, reply taken when its valid pulse shows
  task automatic xfer(input logic w, input logic [PNUM_W-1:0] p,
                      input logic [VAL_W-1:0] v, output psu_rsp_t r);
    @(posedge i_clk);
    #1;
    o_req_valid = 1'b1;
    o_req = {w, p, v};
    @(posedge i_clk);
    #1;
    o_req_valid = 1'b0;
    o_req = ~o_req;
    for (int n = 0; n < 3 && i_rsp_valid !== 1'b1; n++) begin
      @(posedge i_clk);
      #1;
    end
    r = i_rsp;
  endtask
endmodule

// *** sim/test_parameter_set_upload_handshake.sv ***
module test_parameter_set_upload_handshake
  import psu_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic              clk = 1'b0;
  logic              rstn = 1'b0;
  logic              still = 1'b1;
  logic [NPARAM-1:0] card = 256'h220;
  logic              rv, rsp_v, inh, we, per;
  psu_req_t          req;
  psu_rsp_t          rsp, r;
  logic [IDX_W-1:0]  nvm_a;
  logic [VAL_W-1:0]  nvm_d;
  int                n_mismatch = 0, num_checks = 0;
  int                cyc = 0, n_nvm = 0, n_per = 0;
  logic [IDX_W-1:0]  nvm_la;
  logic [VAL_W-1:0]  nvm_ld;
  always #5 clk = ~clk;
  psu_upload psu_upload_i (.i_clk(clk), .i_resetn(rstn), .i_req_valid(rv),
    .i_req(req), .i_standstill(still), .i_card_loadable(card),
    .o_rsp(rsp), .o_rsp_valid(rsp_v), .o_drive_inhibit(inh),
    .o_nvm_we(we), .o_nvm_addr(nvm_a), .o_nvm_data(nvm_d),
    .o_persist_req(per));
  psu_master psu_master_i (.i_clk(clk), .o_req(req), .o_req_valid(rv),
    .i_rsp(rsp), .i_rsp_valid(rsp_v));
  // pulse counters and hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (we === 1'b1) begin
      n_nvm  <= n_nvm + 1;
      nvm_la <= nvm_a;
      nvm_ld <= nvm_d;
    end
    if (per === 1'b1)
      n_per <= n_per + 1;
    if (cyc == 20000) begin
      n_mismatch = n_mismatch + 1;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    if (n_mismatch == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [VAL_W-1:0] got, input logic [VAL_W-1:0] e);
    num_checks++;
    if (got !== e) begin
      n_mismatch++;
      $display("[ERR] %0t got %h expected %h", $time, got, e);
    end
  endtask
  task automatic tel(input logic w, input logic [PNUM_W-1:0] p,
                     input logic [VAL_W-1:0] v);
    psu_master_i.xfer(w, p, v, r);
  endtask
  // read the control value until it leaves busy, bounded
  task automatic poll();
    int k;
    k = 0;
    do begin
      tel(1'b0, PNUM_UPLOAD_CTRL, 32'h0);
      k++;
    end while (r.value === UPC_BUSY && k < 1000);
  endtask
  task automatic s_moving();
    still = 1'b0;
    tel(1'b1, PNUM_UPLOAD_CTRL, UPC_REGISTER);
    chk({24'h0, r.status}, {24'h0, ST_NOTSTILL});
    chk({31'h0, inh}, 32'h0);
    still = 1'b1;
  endtask
  task automatic s_good();
    tel(1'b1, PNUM_UPLOAD_CTRL, UPC_REGISTER);
    chk({31'h0, inh}, 32'h1);
    tel(1'b1, PNUM_PERSIST, 32'h00000001);
    chk({24'h0, r.status}, {24'h0, ST_BADVAL});
    tel(1'b1, 10'h005, 32'h00000012);
    tel(1'b1, 10'h009, 32'h00000056);
    tel(1'b1, 10'h006, 32'h00000034);
    chk({24'h0, r.status}, 32'h0);
    tel(1'b0, 10'h005, 32'h0);
    chk(r.value, 32'h0);
    tel(1'b1, PNUM_UPLOAD_CTRL, UPC_END);
    tel(1'b0, PNUM_UPLOAD_CTRL, 32'h0);
    chk(r.value, UPC_BUSY);
    chk({31'h0, inh}, 32'h1);
    tel(1'b1, 10'h005, 32'h00000001);
    chk({24'h0, r.status}, {24'h0, ST_BADVAL});
    poll();
    chk(r.value, UPC_DONE);
    chk(n_nvm, 32'h2);
    chk({24'h0, nvm_la}, 32'h9);
    chk(nvm_ld, 32'h00000056);
    chk({31'h0, inh}, 32'h0);
    tel(1'b0, 10'h005, 32'h0);
    chk(r.value, 32'h00000012);
    tel(1'b0, 10'h006, 32'h0);
    chk(r.value, 32'h0);
  endtask
  task automatic s_bad();
    n_nvm = 0;
    tel(1'b1, PNUM_UPLOAD_CTRL, UPC_REGISTER);
    tel(1'b1, 10'h009, 32'h80000000);
    chk({24'h0, r.status}, 32'h0);
    tel(1'b1, PNUM_UPLOAD_CTRL, UPC_END);
    poll();
    chk(r.value, 32'h00000009);
    chk(n_nvm, 32'h0);
    chk({31'h0, inh}, 32'h0);
    tel(1'b0, 10'h009, 32'h0);
    chk(r.value, 32'h00000056);
  endtask
  // link lost mid-upload: restart the controller, then repeat it all
  task automatic s_retry();
    tel(1'b1, PNUM_UPLOAD_CTRL, UPC_REGISTER);
    tel(1'b1, 10'h005, 32'h00000077);
    rstn = 1'b0;
    repeat (2) @(posedge clk);
    #1 rstn = 1'b1;
    chk({31'h0, inh}, 32'h0);
    tel(1'b1, PNUM_UPLOAD_CTRL, UPC_REGISTER);
    chk({24'h0, r.status}, 32'h0);
    tel(1'b1, 10'h005, 32'h00000077);
    tel(1'b1, PNUM_UPLOAD_CTRL, UPC_END);
    poll();
    chk(r.value, UPC_DONE);
    tel(1'b0, 10'h005, 32'h0);
    chk(r.value, 32'h00000077);
  endtask
  task automatic s_persist();
    tel(1'b1, PNUM_PERSIST, 32'h00000001);
    chk({24'h0, r.status}, 32'h0);
    @(posedge clk);
    #1;
    chk(n_per, 32'h1);
    tel(1'b1, 10'h005, 32'h80000000);
    chk({24'h0, r.status}, {24'h0, ST_BADVAL});
    tel(1'b0, 10'h005, 32'h0);
    chk(r.value, 32'h00000012);
    tel(1'b0, 10'h3ff, 32'h0);
    chk({24'h0, r.status}, {24'h0, ST_BADNUM});
  endtask
  // main sequence
  initial begin
    repeat (8) @(posedge clk);
    #1 rstn = 1'b1;
    chk({31'h0, inh}, 32'h0);
    tel(1'b0, PNUM_UPLOAD_CTRL, 32'h0);
    chk(r.value, UPC_DONE);
    s_moving();
    s_good();
    s_persist();
    s_bad();
    s_retry();
    report_and_stop();
  end
endmodule
